// ===== hdl/irq_sense.sv
// External interrupt sensing: pin and keyboard lines into one request.
// Assumes asynchronous pin inputs; synchronises them itself.
`timescale 1ns/10ps
`default_nettype none

module irq_sense
(
  input  wire logic       clk,                // System clock
  input  wire logic       reset,              // Synchronous, active high
  input  wire logic       clk_en,             // Freezes state when low
  input  wire logic       irq_pin_n,          // Interrupt pin, active low
  input  wire logic [3:0] keyboard_port_pins, // Keyboard lines, active high
  input  wire logic       edge_only,          // Trigger option
  input  wire logic       kbd_disable,        // Keyboard interrupt option
  output logic            irq_event,          // Request to status
  output logic            req_level           // Combined active request
);

  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic [4:0] sync1_d;
  logic [4:0] sync2_d;
  logic       prev_q;
  logic       prev_d;
  logic       rise;

  ////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers, pin idle high, keys idle low
  always_comb
  begin
    sync1_d = {irq_pin_n, keyboard_port_pins};
    sync2_d = sync1_q;
    prev_d  = req_level;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sync1_q <= 5'h10;
      sync2_q <= 5'h10;
      prev_q  <= 1'b0;
    end
    else if (clk_en)
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q  <= prev_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Keys are ORed in with opposite phase to the pin
  assign req_level = !sync2_q[4] || (!kbd_disable && |sync2_q[3:0]);
  // Falling pin edge equals rising request
  assign rise      = req_level && !prev_q;
  // Same sensitivity for pin and keys
  assign irq_event = rise || (!edge_only && req_level);

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  AST_KBD_MASKED: assert property (kbd_disable |-> req_level == !sync2_q[4])
    else $error("keyboard lines leak into request while disabled");
  AST_EDGE_ONLY: assert property (
    clk_en && edge_only && req_level ##1 clk_en && req_level |-> !irq_event)
    else $error("held request retriggers in edge mode");
  AST_LEVEL: assert property (!edge_only && req_level |-> irq_event)
    else $error("low level not seen in level mode");
  COV_KEY_EDGE: cover property (edge_only && !kbd_disable && rise
                                && sync2_q[4]);

endmodule

`default_nettype wire

// ===== hdl/option_loader.sv
// Option bits, clock dividers, reset pin and interrupt pin control.
// Assumes an AXI4-Lite master on clk and asynchronous external pins.
//
// Summary of operation
// - Five nonvolatile option bits configure trigger, pulls, keys, delay, LOW_VOLTAGE_RESET.
// - Trigger bit one means edge only, zero means edge and level.
// - Pull bit one connects port pull devices, zero disconnects them.
// - Keyboard bit one disables key interrupts, zero enables them.
// - Delay bit one gives 128 cycles, zero gives 4064 cycles.
// - LOW_VOLTAGE_RESET bit one enables low-voltage reset, zero disables it.
// - Internal bus clock is the oscillator divided by two.
// - USB bit clock is the oscillator divided by four.
// - Reset pin low puts the controller into its start-up state.
// - Low-voltage reset drives the reset pin low as an output.
// - Interrupt pin triggers on falling edges, or edges and low level.
// - Enabled key lines are ORed into the request, inverted phase.
// - Pin edge or level choice applies to the key lines too.
// - Any reset makes all eight port A lines inputs.
// - Any reset makes all three port B lines inputs.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/10ps
`default_nettype none

module option_loader
#(
  parameter int OSC_LONG = option_pkg::OSC_LONG_CYCLES // Long start delay
)
(
  input  wire logic        clk,                // 50 MHz oscillator clock
  input  wire logic        reset,              // Power-on, sync, high
  input  wire logic        clk_en,             // Freezes state when low
  input  wire logic [11:0] awaddr,             // Write address
  input  wire logic        awvalid,            // Write address valid
  output logic             awready,            // Write address ready
  input  wire logic [31:0] wdata,              // Write data
  input  wire logic [3:0]  wstrb,              // Write strobes
  input  wire logic        wvalid,             // Write data valid
  output logic             wready,             // Write data ready
  output logic [1:0]       bresp,              // Write response
  output logic             bvalid,             // Write response valid
  input  wire logic        bready,             // Write response ready
  input  wire logic [11:0] araddr,             // Read address
  input  wire logic        arvalid,            // Read address valid
  output logic             arready,            // Read address ready
  output logic [31:0]      rdata,              // Read data
  output logic [1:0]       rresp,              // Read response
  output logic             rvalid,             // Read data valid
  input  wire logic        rready,             // Read data ready
  input  wire logic        reset_pin_n_in,     // Reset pin level
  output logic             reset_pin_out,      // Reset pin drive value
  output logic             reset_pin_oe,       // Reset pin drive enable
  input  wire logic        low_voltage_detect, // Supply below threshold
  input  wire logic        irq_pin_n,          // Interrupt pin, low active
  input  wire logic [3:0]  keyboard_port_pins, // Key lines
  output logic [7:0]       port_a_lines_dir,   // Port A, 1 = output
  output logic [2:0]       port_b_lines_dir,   // Port B, 1 = output
  output logic [7:0]       port_a_pull_en,     // Port A pull-downs
  output logic [2:0]       port_b_pull_en,     // Port B pulls
  output logic             bus_clk,            // Internal bus clock
  output logic             usb_bit_clk,        // Low-speed bit clock
  output logic             osc_ready,          // Start-up delay over
  output logic             controller_reset,   // Reset to controller
  output logic             interrupt           // Level interrupt
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [4:0]  opt_q = option_pkg::OPTION_ERASED;
  logic [4:0]  opt_d;
  logic        awready_q, awready_d, wready_q, wready_d;
  logic        bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d, wdata_q, wdata_d;
  logic [9:0]  widx_q, widx_d;
  logic        wlane_q, wlane_d;
  logic        wr_fire, wr_en, wr_hit;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic        prog_en_q, prog_en_d;
  logic [7:0]  dir_a_q, dir_a_d, pull_a_q, pull_a_d, pa_pull_q, pa_pull_d;
  logic [2:0]  dir_b_q, dir_b_d, pull_b_q, pull_b_d, pb_pull_q, pb_pull_d;
  logic [2:0]  status_q, status_d, mask_q, mask_d, events;
  logic        irq_q, irq_d;
  logic        bus_clk_q, bus_clk_d, usb_clk_q, usb_clk_d;
  logic        oe_q, oe_d, ctl_rst_q, ctl_rst_d;
  logic [11:0] osc_cnt_q, osc_cnt_d, osc_limit;
  logic        osc_done;
  option_pkg::osc_state_t osc_q, osc_d;
  logic [1:0]  pin_s1_q, pin_s2_q;
  logic        rst_pin_s, lvd_s, lvr_fire, soft_rst;
  logic        irq_event, req_level;

  ////////////////////////////////////////////////////////////////////////
  // Reset pin and supply detector synchronisers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pin_s1_q <= 2'h2;
      pin_s2_q <= 2'h2;
    end
    else if (clk_en)
    begin
      pin_s1_q <= {reset_pin_n_in, low_voltage_detect};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign rst_pin_s = pin_s2_q[1];
  assign lvd_s     = pin_s2_q[0];
  // Detector acts only when its option is set
  assign lvr_fire  = lvd_s && opt_q[option_pkg::BIT_LVR];
  // Pin low or low-voltage: whole controller restarts
  assign soft_rst  = !rst_pin_s || lvr_fire;

  ////////////////////////////////////////////////////////////////////////
  // Interrupt pin and keyboard lines
  irq_sense u_sense
  (
    .clk                (clk),
    .reset              (reset),
    .clk_en             (clk_en),
    .irq_pin_n          (irq_pin_n),
    .keyboard_port_pins (keyboard_port_pins),
    .edge_only          (opt_q[option_pkg::BIT_TRIG]),
    .kbd_disable        (opt_q[option_pkg::BIT_KBD_DIS]),
    .irq_event          (irq_event),
    .req_level          (req_level)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register read decode; unmapped words answer with an error
  always_comb
  begin
    rd_word = 32'h0;
    rd_hit  = 1'b1;
    case (araddr[11:2])
      option_pkg::IDX_OPTION:    rd_word[4:0] = opt_q;
      option_pkg::IDX_PROG_CTRL: rd_word[option_pkg::BIT_PROG_EN] = prog_en_q;
      option_pkg::IDX_DIR_A:     rd_word[7:0] = dir_a_q;
      option_pkg::IDX_DIR_B:     rd_word[2:0] = dir_b_q;
      option_pkg::IDX_PULL_A:    rd_word[7:0] = pull_a_q;
      option_pkg::IDX_PULL_B:    rd_word[2:0] = pull_b_q;
      option_pkg::IDX_STATUS:    rd_word[2:0] = status_q;
      option_pkg::IDX_MASK:      rd_word[2:0] = mask_q;
      default:                   rd_hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Write address and data may arrive in either order
  assign wr_fire = !awready_q && !wready_q && !bvalid_q;
  assign wr_en   = wr_fire && wlane_q;

  always_comb
  begin
    case (widx_q)
      option_pkg::IDX_OPTION, option_pkg::IDX_PROG_CTRL,
      option_pkg::IDX_DIR_A, option_pkg::IDX_DIR_B,
      option_pkg::IDX_PULL_A, option_pkg::IDX_PULL_B,
      option_pkg::IDX_STATUS, option_pkg::IDX_MASK: wr_hit = 1'b1;
      default:                                       wr_hit = 1'b0;
    endcase
  end

  // Bus channel handshakes, one write and one read in flight
  always_comb
  begin
    awready_d = awready_q;
    wready_d  = wready_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    widx_d    = widx_q;
    wdata_d   = wdata_q;
    wlane_d   = wlane_q;
    arready_d = arready_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (awready_q && awvalid)
    begin
      widx_d    = awaddr[11:2];
      awready_d = 1'b0;
    end
    if (wready_q && wvalid)
    begin
      wdata_d  = wdata;
      wlane_d  = wstrb[0];
      wready_d = 1'b0;
    end
    if (wr_fire)
    begin
      bvalid_d = 1'b1;
      bresp_d  = wr_hit ? option_pkg::RESP_OKAY : option_pkg::RESP_SLVERR;
    end
    if (bvalid_q && bready)
    begin
      bvalid_d  = 1'b0;
      awready_d = 1'b1;
      wready_d  = 1'b1;
    end
    if (arready_q && arvalid)
    begin
      arready_d = 1'b0;
      rvalid_d  = 1'b1;
      rdata_d   = rd_word;
      rresp_d   = rd_hit ? option_pkg::RESP_OKAY : option_pkg::RESP_SLVERR;
    end
    if (rvalid_q && rready)
    begin
      rvalid_d  = 1'b0;
      arready_d = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= option_pkg::RESP_OKAY;
      widx_q    <= 10'h0;
      wdata_q   <= 32'h0;
      wlane_q   <= 1'b0;
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= option_pkg::RESP_OKAY;
    end
    else if (clk_en)
    begin
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      widx_q    <= widx_d;
      wdata_q   <= wdata_d;
      wlane_q   <= wlane_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Nonvolatile options: programming only clears erased ones
  always_comb
  begin
    opt_d = opt_q;
    if (wr_en && widx_q == option_pkg::IDX_OPTION && prog_en_q)
      opt_d = opt_q & wdata_q[4:0];
  end

  // No reset term: options survive every reset
  always_ff @(posedge clk)
  begin
    if (clk_en)
      opt_q <= opt_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // Start-up delay length from the option bit
  assign osc_limit = opt_q[option_pkg::BIT_OSC]
                   ? 12'(option_pkg::OSC_SHORT_CYCLES) : 12'(OSC_LONG);
  assign osc_done  = bus_clk_q && osc_cnt_q == osc_limit - 12'h1;
  assign events    = {osc_q == option_pkg::OSC_WAIT && osc_done,
                      lvr_fire, irq_event};

  // Control registers, dividers, start-up sequencer
  always_comb
  begin
    prog_en_d = prog_en_q;
    dir_a_d   = dir_a_q;
    dir_b_d   = dir_b_q;
    pull_a_d  = pull_a_q;
    pull_b_d  = pull_b_q;
    mask_d    = mask_q;
    status_d  = status_q;
    osc_d     = osc_q;
    osc_cnt_d = osc_cnt_q;
    // Toggle every clock: half rate
    bus_clk_d = !bus_clk_q;
    // Toggle on every other clock: quarter rate
    usb_clk_d = bus_clk_q ? !usb_clk_q : usb_clk_q;
    if (wr_en)
    begin
      case (widx_q)
        option_pkg::IDX_PROG_CTRL:
          prog_en_d = wdata_q[option_pkg::BIT_PROG_EN];
        option_pkg::IDX_DIR_A:  dir_a_d  = wdata_q[7:0];
        option_pkg::IDX_DIR_B:  dir_b_d  = wdata_q[2:0];
        option_pkg::IDX_PULL_A: pull_a_d = wdata_q[7:0];
        option_pkg::IDX_PULL_B: pull_b_d = wdata_q[2:0];
        option_pkg::IDX_STATUS: status_d = status_q & ~wdata_q[2:0];
        option_pkg::IDX_MASK:   mask_d   = wdata_q[2:0];
        default:                mask_d   = mask_q;
      endcase
    end
    // Set wins over a clear in the same cycle
    status_d = status_d | events;
    case (osc_q)
      option_pkg::OSC_WAIT:
      begin
        if (bus_clk_q)
          osc_cnt_d = osc_cnt_q + 12'h1;
        if (osc_done)
          osc_d = option_pkg::OSC_RUN;
      end
      option_pkg::OSC_RUN: osc_cnt_d = osc_cnt_q;
      default:             osc_d = option_pkg::OSC_WAIT;
    endcase
    // Any reset source: ports to inputs, delay restarts
    if (soft_rst)
    begin
      prog_en_d = 1'b0;
      dir_a_d   = option_pkg::DIR_A_RESET;
      dir_b_d   = option_pkg::DIR_B_RESET;
      pull_a_d  = 8'h00;
      pull_b_d  = 3'h0;
      osc_d     = option_pkg::OSC_WAIT;
      osc_cnt_d = 12'h0;
    end
    // Pulls reach the pins only with the option set
    pa_pull_d = opt_q[option_pkg::BIT_PULL] ? pull_a_d : 8'h00;
    pb_pull_d = opt_q[option_pkg::BIT_PULL] ? pull_b_d : 3'h0;
    irq_d     = |(status_d & mask_d);
    // Drive the reset pin low while low-voltage reset holds
    oe_d      = lvr_fire;
    ctl_rst_d = soft_rst || osc_d == option_pkg::OSC_WAIT;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      prog_en_q <= 1'b0;
      dir_a_q   <= option_pkg::DIR_A_RESET;
      dir_b_q   <= option_pkg::DIR_B_RESET;
      pull_a_q  <= 8'h00;
      pull_b_q  <= 3'h0;
      pa_pull_q <= 8'h00;
      pb_pull_q <= 3'h0;
      status_q  <= 3'h0;
      mask_q    <= 3'h0;
      irq_q     <= 1'b0;
      bus_clk_q <= 1'b0;
      usb_clk_q <= 1'b0;
      osc_q     <= option_pkg::OSC_WAIT;
      osc_cnt_q <= 12'h0;
      oe_q      <= 1'b0;
      ctl_rst_q <= 1'b1;
    end
    else if (clk_en)
    begin
      prog_en_q <= prog_en_d;
      dir_a_q   <= dir_a_d;
      dir_b_q   <= dir_b_d;
      pull_a_q  <= pull_a_d;
      pull_b_q  <= pull_b_d;
      pa_pull_q <= pa_pull_d;
      pb_pull_q <= pb_pull_d;
      status_q  <= status_d;
      mask_q    <= mask_d;
      irq_q     <= irq_d;
      bus_clk_q <= bus_clk_d;
      usb_clk_q <= usb_clk_d;
      osc_q     <= osc_d;
      osc_cnt_q <= osc_cnt_d;
      oe_q      <= oe_d;
      ctl_rst_q <= ctl_rst_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs from flip-flops except osc_ready, decoded from osc_q; pin drive value is always low
  assign awready          = awready_q;
  assign wready           = wready_q;
  assign bvalid           = bvalid_q;
  assign bresp            = bresp_q;
  assign arready          = arready_q;
  assign rvalid           = rvalid_q;
  assign rdata            = rdata_q;
  assign rresp            = rresp_q;
  assign reset_pin_out    = 1'b0;
  assign reset_pin_oe     = oe_q;
  assign port_a_lines_dir = dir_a_q;
  assign port_b_lines_dir = dir_b_q;
  assign port_a_pull_en   = pa_pull_q;
  assign port_b_pull_en   = pb_pull_q;
  assign bus_clk          = bus_clk_q;
  assign usb_bit_clk      = usb_clk_q;
  assign osc_ready        = osc_q == option_pkg::OSC_RUN;
  assign controller_reset = ctl_rst_q;
  assign interrupt        = irq_q;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  AST_OPT_LOCKED: assert property (
    clk_en && !prog_en_q |=> opt_q == $past(opt_q))
    else $error("options changed without program enable");
  AST_OPT_KEEP: assert property (
    soft_rst |=> opt_q == $past(opt_q))
    else $error("options disturbed by reset");
  AST_TRIG_LEVEL: assert property (
    clk_en && !opt_q[option_pkg::BIT_TRIG] && req_level && mask_q[0]
    |=> status_q[0] && interrupt)
    else $error("held low level did not raise interrupt");
  AST_PULL_OFF: assert property (
    clk_en && !opt_q[option_pkg::BIT_PULL]
    |=> port_a_pull_en == 8'h00 && port_b_pull_en == 3'h0)
    else $error("pulls connected while option clear");
  AST_OSC_LEN: assert property (
    clk_en && $past(clk_en) && $rose(osc_ready)
    |-> $past(osc_cnt_q) == $past(osc_limit) - 12'h1)
    else $error("start-up delay length wrong");
  AST_LVR_DRIVE: assert property (
    clk_en && lvd_s |=> reset_pin_oe == opt_q[option_pkg::BIT_LVR]
                        && controller_reset == opt_q[option_pkg::BIT_LVR]
                        || controller_reset)
    else $error("reset pin not driven on low voltage");
  AST_BUS_DIV: assert property (
    clk_en && $past(clk_en) && !$past(reset) |-> bus_clk != $past(bus_clk))
    else $error("bus clock not half rate");
  AST_USB_DIV: assert property (
    clk_en && $past(clk_en) && !$past(reset) && $changed(usb_bit_clk)
    |-> $fell(bus_clk))
    else $error("usb clock not quarter rate");
  AST_PIN_RESET: assert property (
    clk_en && !rst_pin_s |=> controller_reset && !osc_ready)
    else $error("reset pin low did not reset controller");
  AST_DIR_CLEAR: assert property (
    clk_en && soft_rst |=> port_a_lines_dir == 8'h00
                          && port_b_lines_dir == 3'h0)
    else $error("ports not inputs after reset");

  COV_OSC_READY: cover property ($rose(osc_ready));
  COV_LVR: cover property ($rose(reset_pin_oe));
  COV_LEVEL_IRQ: cover property (!opt_q[option_pkg::BIT_TRIG] && interrupt);
  COV_OPT_WRITE: cover property (opt_q != $past(opt_q));

endmodule

`default_nettype wire

// ===== shared/option_pkg.sv
// Constants for the option bits and pin control block.
// Assumes a 50 MHz clock and an AXI4-Lite register bus with 32-bit data.
`default_nettype none

package option_pkg;

  // Bus address width and responses
  localparam int          ADDR_W      = 12;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Register indices; byte address is four times the index
  localparam logic [9:0]  IDX_OPTION    = 10'h1FF;
  localparam logic [9:0]  IDX_PROG_CTRL = 10'h03E;
  localparam logic [9:0]  IDX_DIR_A     = 10'h004;
  localparam logic [9:0]  IDX_DIR_B     = 10'h005;
  localparam logic [9:0]  IDX_PULL_A    = 10'h010;
  localparam logic [9:0]  IDX_PULL_B    = 10'h011;
  localparam logic [9:0]  IDX_STATUS    = 10'h040;
  localparam logic [9:0]  IDX_MASK      = 10'h041;

  // Option field positions and erased value
  localparam int          OPT_W         = 5;
  localparam int          BIT_TRIG      = 4;
  localparam int          BIT_PULL      = 3;
  localparam int          BIT_KBD_DIS   = 2;
  localparam int          BIT_OSC       = 1;
  localparam int          BIT_LVR       = 0;
  localparam logic [4:0]  OPTION_ERASED = 5'h1F;

  // Program control field
  localparam int          BIT_PROG_EN   = 3;

  // Interrupt status layout
  localparam int          STATUS_W      = 3;
  localparam int          ST_EXT        = 0;
  localparam int          ST_LVR        = 1;
  localparam int          ST_OSC        = 2;

  // Port widths and reset values
  localparam int          PA_W          = 8;
  localparam int          PB_W          = 3;
  localparam int          KBD_W         = 4;
  localparam logic [7:0]  DIR_A_RESET   = 8'h00;
  localparam logic [2:0]  DIR_B_RESET   = 3'h0;

  // Oscillator start-up delay in internal bus cycles
  localparam int          OSC_CNT_W        = 12;
  localparam int          OSC_SHORT_CYCLES = 128;
  localparam int          OSC_LONG_CYCLES  = 4064;

  // Start-up sequencer states
  typedef enum logic [1:0] {
    OSC_WAIT = 2'h1,
    OSC_RUN  = 2'h2
  } osc_state_t;

endpackage

`default_nettype wire

// ===== sim/option_bits_and_pin_control_tb.sv
// Bench for option_loader: bus tasks, pin partner, queued answers.
// Assumes one 50 MHz clock; bench reset held for 8 cycles.
`timescale 1ns/10ps
`default_nettype none
module option_bits_and_pin_control_tb;
  logic clk = 0, reset = 1, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, irq_req = 0, rst_req = 0;
  logic low_voltage_detect = 0, awready, wready, bvalid, arready, rvalid;
  logic reset_pin_n_in, reset_pin_out, reset_pin_oe, irq_pin_n;
  logic osc_ready, interrupt, bus_clk, usb_bit_clk, controller_reset;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, x;
  logic [3:0]  key_req = 0, keyboard_port_pins;
  logic [1:0]  bresp, rresp, s;
  logic [7:0]  port_a_lines_dir, port_a_pull_en;
  logic [2:0]  port_b_lines_dir, port_b_pull_en;
  logic [34:0] q[$], e;
  int          err_total = 0, checks = 0, n;
  always #10 clk = !clk;
  option_loader #(.OSC_LONG(16)) dut (.clk, .reset, .clk_en(1'b1),
    .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .reset_pin_n_in, .reset_pin_out, .reset_pin_oe,
    .low_voltage_detect, .irq_pin_n, .keyboard_port_pins,
    .port_a_lines_dir, .port_b_lines_dir, .port_a_pull_en,
    .port_b_pull_en, .bus_clk, .usb_bit_clk, .osc_ready,
    .controller_reset, .interrupt);
  pin_partner part (.irq_req, .key_req, .rst_req, .oe(reset_pin_oe),
    .out(reset_pin_out), .irq_n(irq_pin_n), .keys(keyboard_port_pins),
    .rst_n(reset_pin_n_in));
  task automatic chk(input string nm, input logic [33:0] ex, sn);
    checks++;
    if (sn !== ex)
    begin
      $display("ERROR %s expected %h seen %h", nm, ex, sn);
      err_total++;
    end
  endtask
  task automatic close_out;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Write: both channels offered, each released once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    q.push_back({1'b1, option_pkg::RESP_OKAY, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (awvalid && !awready || wvalid && !wready);
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] r = option_pkg::RESP_OKAY);
    q.push_back({1'b0, r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b0;
  endtask
  // Oldest note against each answer; reads and writes never overlap
  always @(posedge clk)
    if (bvalid && bready || rvalid && rready)
    begin
      e = q.pop_front();
      if (e[34]) chk("bresp", e[33:32], bresp);
      else chk("read", e[33:0], {rresp, rdata});
    end
  // Long enough for every scenario with margin
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    close_out();
  end
  initial
  begin
    x = $urandom(32'h93C2);
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk("dir_a", 0, port_a_lines_dir);
    chk("dir_b", 0, port_b_lines_dir);
    rd(12'h7FC, 32'h1F);
    wr(12'h010, x);
    rd(12'h010, {24'h0, x[7:0]});
    rst_req <= 1'b1;
    repeat (6) @(posedge clk);
    rst_req <= 1'b0;
    repeat (6) @(posedge clk);
    rd(12'h010, 32'h0);
    rd(12'h200, 32'h0, option_pkg::RESP_SLVERR);
    wr(12'h104, 32'h1);
    key_req <= 4'h4;
    repeat (6) @(posedge clk);
    chk("int_kbd_off", 0, interrupt);
    key_req <= 4'h0;
    wr(12'h0F8, 32'h8);
    wr(12'h040, 32'hFF);
    chk("pull_a", 8'hFF, port_a_pull_en);
    wr(12'h7FC, 32'h1B);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    n = 0;
    while (osc_ready !== 1'b1 && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    chk("osc_delay", 1, n > 240 && n < 270);
    rd(12'h7FC, 32'h1B);
    chk("ctl_rst", 0, controller_reset);
    wr(12'h104, 32'h1);
    key_req <= 4'h2;
    repeat (6) @(posedge clk);
    chk("int_kbd", 1, interrupt);
    key_req <= 4'h0;
    repeat (4) @(posedge clk);
    wr(12'h100, 32'h1);
    @(posedge clk);
    chk("int_clr", 0, interrupt);
    irq_req <= 1'b1;
    repeat (6) @(posedge clk);
    chk("int_pin", 1, interrupt);
    wr(12'h100, 32'h1);
    @(posedge clk);
    chk("int_edge", 0, interrupt);
    irq_req <= 1'b0;
    #1 s = {usb_bit_clk, bus_clk};
    @(posedge clk);
    #1 chk("bus_clk", !s[0], bus_clk);
    @(posedge clk);
    #1 chk("usb_clk", !s[1], usb_bit_clk);
    wr(12'h044, 32'h7);
    chk("pull_b", 3'h7, port_b_pull_en);
    wr(12'h0F8, 32'h8);
    wr(12'h7FC, 32'h3);
    wr(12'h040, 32'hFF);
    chk("pull_off", 0, {port_a_pull_en, port_b_pull_en});
    irq_req <= 1'b1;
    repeat (6) @(posedge clk);
    wr(12'h100, 32'h1);
    @(posedge clk);
    chk("int_level", 1, interrupt);
    irq_req <= 1'b0;
    low_voltage_detect <= 1'b1;
    repeat (4) @(posedge clk);
    chk("rst_oe", 1, reset_pin_oe);
    low_voltage_detect <= 1'b0;
    close_out();
  end
endmodule
`default_nettype wire

// ===== sim/pin_partner.sv
// Pins outside the block: interrupt, key lines, reset pin wire.
// Assumes the bench sets the wanted levels on the request inputs.
`timescale 1ns/10ps
`default_nettype none
module pin_partner
(
  input  wire logic       irq_req, // Wanted interrupt request
  input  wire logic [3:0] key_req, // Wanted key levels
  input  wire logic       rst_req, // Reset button pressed
  input  wire logic       oe,      // Block drives reset pin
  input  wire logic       out,     // Block drive value
  output logic            irq_n,   // Interrupt pin level
  output logic [3:0]      keys,    // Key lines
  output logic            rst_n    // Reset pin wire
);
  // Pull-up on the reset pin; the block's drive wins over the button
  assign rst_n = oe ? out : !rst_req;
  assign irq_n = !irq_req;
  assign keys = key_req;
endmodule
`default_nettype wire
